//--- src/queue_stack_pkg.sv
// shared constants and types for the queue/stack memory
package queue_stack_pkg;

	// ------------------------------------------------------------------
	// storage geometry
	// ------------------------------------------------------------------
	localparam int          DATA_W   = 4;
	localparam int          ENTRIES  = 30;
	localparam logic [4:0]  DISP_MAX = 5'h9;

	// ------------------------------------------------------------------
	// register offsets (byte addresses, address bits 7:2 decoded)
	// ------------------------------------------------------------------
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_STATUS     = 8'h04;
	localparam logic [7:0]  OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0]  OFF_IRQ_MASK   = 8'h0C;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int          CTRL_PUSH_BIT  = 0;
	localparam int          CTRL_POP_BIT   = 1;
	localparam int          CTRL_DATA_LSB  = 4;
	localparam int          STAT_COUNT_LSB = 0;
	localparam int          STAT_FULL_BIT  = 5;
	localparam int          STAT_EMPTY_BIT = 6;
	localparam int          STAT_VALID_BIT = 7;
	localparam int          STAT_OVF_BIT   = 8;
	localparam int          STAT_MODE_BIT  = 9;
	localparam int          STAT_DATA_LSB  = 12;

	// ------------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------------
	localparam int          EV_WR_OK    = 0;
	localparam int          EV_WR_FULL  = 1;
	localparam int          EV_RD_OK    = 2;
	localparam int          EV_RD_EMPTY = 3;
	localparam int          EV_FULL     = 4;
	localparam int          EV_OVF      = 5;
	localparam int          EV_N        = 6;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [5:0]  IRQ_MASK_RST = 6'h00;
	localparam logic [3:0]  RDATA_RST    = 4'h0;

	typedef enum logic [1:0] {ACC_NONE, ACC_WRITE, ACC_READ} access_t;

endpackage : queue_stack_pkg

//--- src/entry_mem_if.sv
// port bundle between the pointer logic and the entry storage
`timescale 1ns/1ps
interface entry_mem_if #(
	parameter int DW = 4,
	parameter int AW = 5
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic          re;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctrl  (output we, waddr, wdata, re, raddr, input rdata);
	modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : entry_mem_if

//--- src/entry_memory.sv
// entry storage with registered read data
`timescale 1ns/1ps
module entry_memory #(
	parameter int DEPTH = 30,
	parameter int DW    = 4
) (
	// clock and reset
	input  wire logic   core_clk_i,
	input  wire logic   resetn_i,
	// storage port
	entry_mem_if.store  mem
);
	import queue_stack_pkg::*;

	logic [DW-1:0] store [DEPTH];
	logic [DW-1:0] rdata;
	logic [DW-1:0] next_rdata;

	// read data holds its last value while no read takes place
	always_comb
	begin
		next_rdata = mem.re ? store[mem.raddr] : rdata;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (mem.we)
			store[mem.waddr] <= mem.wdata;
		if (!resetn_i)
			rdata <= DW'(RDATA_RST);
		else
			rdata <= next_rdata;
	end

	assign mem.rdata = rdata;
endmodule : entry_memory

//--- src/seg_encoder.sv
// decimal digit to seven segment pattern, segments a..g in bits 0..6
`timescale 1ns/1ps
module seg_encoder (
	// digit in
	input  wire logic [3:0] digit_i,
	input  wire logic       blank_i,
	// segments out, active high
	output logic      [6:0] seg_o
);
	always_comb
	begin
		if (blank_i)
			seg_o = 7'h00;
		else
			case (digit_i)
				4'h0:    seg_o = 7'h3F;
				4'h1:    seg_o = 7'h06;
				4'h2:    seg_o = 7'h5B;
				4'h3:    seg_o = 7'h4F;
				4'h4:    seg_o = 7'h66;
				4'h5:    seg_o = 7'h6D;
				4'h6:    seg_o = 7'h7D;
				4'h7:    seg_o = 7'h07;
				4'h8:    seg_o = 7'h7F;
				4'h9:    seg_o = 7'h6F;
				default: seg_o = 7'h00;
			endcase
	end
endmodule : seg_encoder

//--- src/dual_mode_queue_stack_memory.sv
// queue/stack entry memory with count display, flags and bus registers
//
// Overview of operation
// - mode low reads oldest entry first, mode high reads newest first.
// - storage holds up to thirty entries of four bits each.
// - mode changes leave stored entries and count untouched.
// - display shows the entry count as a digit while count is nine or less.
// - above nine entries the display blanks and the overflow flag rises.
// - a write while full is ignored; contents and count stay.
// - a read while empty clears the output-valid flag.
// - output-valid stays low from reset until the first read.
`timescale 1ns/1ps
module dual_mode_queue_stack_memory #(
	parameter int DW    = queue_stack_pkg::DATA_W,
	parameter int DEPTH = queue_stack_pkg::ENTRIES
) (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// user switches
	input  wire logic [DW-1:0] data_in_i,
	input  wire logic        write_en_i,
	input  wire logic        read_en_i,
	input  wire logic        mode_i,
	input  wire logic        manual_clk_i,
	// display
	output logic      [6:0]  seg_o,
	output logic             dot_o,
	// indicators
	output logic      [DW-1:0] data_out_o,
	output logic             full_o,
	output logic             empty_o,
	output logic             valid_o,
	output logic             disp_ovf_o,
	output logic             irq_o
);
	import queue_stack_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// circular index step, wraps at the storage depth
	function automatic logic [AW-1:0] wrap_add(input logic [AW-1:0] base,
			input logic [CW-1:0] off);
		int s;
		s = int'(base) + int'(off);
		if (s >= DEPTH)
			s = s - DEPTH;
		return AW'(s);
	endfunction : wrap_add

	// word decode; upper address bits alias
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction : reg_hit

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic            prev_mclk;
	logic            next_prev_mclk;
	logic [AW-1:0]   head;
	logic [AW-1:0]   next_head;
	logic [CW-1:0]   count;
	logic [CW-1:0]   next_count;
	logic            full;
	logic            next_full;
	logic            empty;
	logic            next_empty;
	logic            valid;
	logic            next_valid;
	logic            ovf;
	logic            next_ovf;
	logic [6:0]      seg;
	logic [6:0]      next_seg;
	logic [6:0]      seg_code;
	logic            dot;
	logic            next_dot;

	logic            dp_write;
	logic            next_dp_write;
	logic [7:0]      dp_addr;
	logic [7:0]      next_dp_addr;
	logic [31:0]     rdata;
	logic [31:0]     next_rdata;
	logic            sw_push;
	logic            next_sw_push;
	logic            sw_pop;
	logic            next_sw_pop;
	logic [DW-1:0]   sw_data;
	logic [DW-1:0]   next_sw_data;
	logic [EV_N-1:0] irq_status;
	logic [EV_N-1:0] next_irq_status;
	logic [EV_N-1:0] irq_mask;
	logic [EV_N-1:0] next_irq_mask;
	logic            irq;
	logic            next_irq;

	access_t         acc;
	logic [DW-1:0]   acc_data;
	logic            pin_edge;
	logic            wr_ok;
	logic            wr_full;
	logic            rd_ok;
	logic            rd_empty;
	logic [EV_N-1:0] ev;
	logic            ap_valid;
	logic [31:0]     status_word;

	entry_mem_if #(.DW(DW), .AW(AW)) mem ();

	entry_memory #(.DEPTH(DEPTH), .DW(DW)) u_store (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.mem        (mem.store)
	);

	seg_encoder u_seg (
		.digit_i (next_count[3:0]),
		.blank_i (next_ovf),
		.seg_o   (seg_code)
	);

	// ------------------------------------------------------------------
	// access selection
	// ------------------------------------------------------------------
	// switches win over a software command in the same cycle; the
	// command is then dropped, which keeps one access per cycle
	always_comb
	begin
		next_prev_mclk = manual_clk_i;
		pin_edge       = manual_clk_i & ~prev_mclk;
		acc            = ACC_NONE;
		acc_data       = data_in_i;
		if (pin_edge)
		begin
			if (write_en_i)
				acc = ACC_WRITE;
			else if (read_en_i)
				acc = ACC_READ;
		end
		else if (sw_push)
		begin
			acc      = ACC_WRITE;
			acc_data = sw_data;
		end
		else if (sw_pop)
			acc = ACC_READ;
	end

	// ------------------------------------------------------------------
	// pointer and flag logic
	// ------------------------------------------------------------------
	always_comb
	begin
		wr_ok    = (acc == ACC_WRITE) && !full;
		wr_full  = (acc == ACC_WRITE) && full;
		rd_ok    = (acc == ACC_READ) && !empty;
		rd_empty = (acc == ACC_READ) && empty;

		// next free slot follows the oldest by count
		mem.we    = wr_ok;
		mem.waddr = wrap_add(head, count);
		mem.wdata = acc_data;
		mem.re    = rd_ok;
		// queue reads oldest, stack reads newest
		mem.raddr = mode_i ? wrap_add(head, count - CNT_ONE) : head;

		// mode steers the read address and whether a read advances head, never the contents
		next_head  = (rd_ok && !mode_i) ? wrap_add(head, CNT_ONE) : head;
		next_count = count;
		if (wr_ok)
			next_count = count + CNT_ONE;
		else if (rd_ok)
			next_count = count - CNT_ONE;

		// flags follow the new count on the same edge
		next_full  = next_count == CNT_FULL;
		next_empty = next_count == '0;

		// empty read invalidates; only a read can set it
		next_valid = valid;
		if (rd_ok)
			next_valid = 1'b1;
		else if (rd_empty)
			next_valid = 1'b0;

		next_ovf = 5'(next_count) > DISP_MAX;
		next_seg = seg_code;
		next_dot = mode_i;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			prev_mclk <= 1'b0;
			head      <= '0;
			count     <= '0;
			full      <= 1'b0;
			empty     <= 1'b1;
			valid     <= 1'b0;
			ovf       <= 1'b0;
			seg       <= 7'h3F;
			dot       <= 1'b0;
		end
		else
		begin
			prev_mclk <= next_prev_mclk;
			head      <= next_head;
			count     <= next_count;
			full      <= next_full;
			empty     <= next_empty;
			valid     <= next_valid;
			ovf       <= next_ovf;
			seg       <= next_seg;
			dot       <= next_dot;
		end
	end

	// ------------------------------------------------------------------
	// bus slave and interrupts
	// ------------------------------------------------------------------
	// zero wait states: the read word is sampled at the address phase,
	// so it shows state as of that edge
	always_comb
	begin
		ap_valid      = hsel_i & htrans_i[1] & hready_i;
		next_dp_write = ap_valid & hwrite_i;
		next_dp_addr  = ap_valid ? haddr_i[7:0] : dp_addr;

		status_word = '0;
		status_word[STAT_COUNT_LSB +: CW] = count;
		status_word[STAT_FULL_BIT]  = full;
		status_word[STAT_EMPTY_BIT] = empty;
		status_word[STAT_VALID_BIT] = valid;
		status_word[STAT_OVF_BIT]   = ovf;
		status_word[STAT_MODE_BIT]  = mode_i;
		status_word[STAT_DATA_LSB +: DW] = mem.rdata;

		next_rdata = rdata;
		if (ap_valid && !hwrite_i)
		begin
			next_rdata = '0;
			if (reg_hit(haddr_i[7:0], OFF_STATUS))
				next_rdata = status_word;
			else if (reg_hit(haddr_i[7:0], OFF_IRQ_STATUS))
				next_rdata[EV_N-1:0] = irq_status;
			else if (reg_hit(haddr_i[7:0], OFF_IRQ_MASK))
				next_rdata[EV_N-1:0] = irq_mask;
		end

		next_sw_push = dp_write && reg_hit(dp_addr, OFF_CTRL) && hwdata_i[CTRL_PUSH_BIT];
		next_sw_pop  = dp_write && reg_hit(dp_addr, OFF_CTRL) && hwdata_i[CTRL_POP_BIT];
		next_sw_data = hwdata_i[CTRL_DATA_LSB +: DW];

		next_irq_mask = irq_mask;
		if (dp_write && reg_hit(dp_addr, OFF_IRQ_MASK))
			next_irq_mask = hwdata_i[EV_N-1:0];

		ev = '0;
		ev[EV_WR_OK]    = wr_ok;
		ev[EV_WR_FULL]  = wr_full;
		ev[EV_RD_OK]    = rd_ok;
		ev[EV_RD_EMPTY] = rd_empty;
		ev[EV_FULL]     = next_full & ~full;
		ev[EV_OVF]      = next_ovf & ~ovf;

		// write one to clear; a new event in the same cycle wins
		next_irq_status = irq_status;
		if (dp_write && reg_hit(dp_addr, OFF_IRQ_STATUS))
			next_irq_status = irq_status & ~hwdata_i[EV_N-1:0];
		next_irq_status = next_irq_status | ev;
		next_irq        = |(next_irq_status & next_irq_mask);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			dp_write   <= 1'b0;
			dp_addr    <= '0;
			rdata      <= '0;
			sw_push    <= 1'b0;
			sw_pop     <= 1'b0;
			sw_data    <= '0;
			irq_status <= '0;
			irq_mask   <= IRQ_MASK_RST;
			irq        <= 1'b0;
		end
		else
		begin
			dp_write   <= next_dp_write;
			dp_addr    <= next_dp_addr;
			rdata      <= next_rdata;
			sw_push    <= next_sw_push;
			sw_pop     <= next_sw_pop;
			sw_data    <= next_sw_data;
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			irq        <= next_irq;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign hrdata_o    = rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign seg_o       = seg;
	assign dot_o       = dot;
	assign data_out_o  = mem.rdata;
	assign full_o      = full;
	assign empty_o     = empty;
	assign valid_o     = valid;
	assign disp_ovf_o  = ovf;
	assign irq_o       = irq;
endmodule : dual_mode_queue_stack_memory

//--- testbench/queue_stack_properties.sv
// concurrent checks on the queue/stack memory ports
`timescale 1ns/1ps
module queue_stack_properties (
	// clock and reset
	input wire logic       core_clk_i,
	input wire logic       resetn_i,
	// switches
	input wire logic       write_en_i,
	input wire logic       read_en_i,
	input wire logic       manual_clk_i,
	// indicators
	input wire logic [6:0] seg_o,
	input wire logic       full_o,
	input wire logic       empty_o,
	input wire logic       valid_o,
	input wire logic       disp_ovf_o,
	input wire logic       irq_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// ------------------------------------------------------------------
	// manual clock edge, seen the same way the block sees it
	// ------------------------------------------------------------------
	logic prev_clk;
	logic rise;
	always_ff @(posedge core_clk_i)
	begin
		prev_clk <= resetn_i ? manual_clk_i : 1'b0;
	end
	assign rise = manual_clk_i & ~prev_clk;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	a_flags_exclusive: assert property (!(full_o && empty_o))
		else $error("full and empty together");
	a_ovf_blanks: assert property (disp_ovf_o |-> seg_o == 7'h00)
		else $error("display lit during overflow");
	a_digit_lit: assert property (!disp_ovf_o |-> seg_o != 7'h00)
		else $error("display dark without overflow");
	a_full_ovf: assert property (full_o |-> disp_ovf_o)
		else $error("full without overflow flag");
	a_empty_zero: assert property (empty_o |-> seg_o == 7'h3F)
		else $error("empty but digit not zero");
	a_full_write_kept: assert property (rise && write_en_i && full_o |=> full_o && !empty_o)
		else $error("write while full changed state");
	a_empty_read_inv: assert property
		(rise && read_en_i && !write_en_i && empty_o |=> !valid_o && empty_o)
		else $error("read while empty left valid set");
	a_first_write: assert property (rise && write_en_i && empty_o |=> !empty_o ##1 !empty_o)
		else $error("write into empty did not clear empty");
	a_reset_state: assert property (disable iff (1'b0)
		!resetn_i |=> !valid_o && empty_o && !full_o && !irq_o)
		else $error("state after reset wrong");

	c_full: cover property (full_o);
	c_empty_read: cover property (rise && read_en_i && empty_o);
	c_irq: cover property (irq_o ##1 !irq_o);
endmodule : queue_stack_properties

bind dual_mode_queue_stack_memory queue_stack_properties props_u (
	.core_clk_i, .resetn_i, .write_en_i, .read_en_i, .manual_clk_i,
	.seg_o, .full_o, .empty_o, .valid_o, .disp_ovf_o, .irq_o);

//--- testbench/switch_panel_model.sv
// user switch panel: data switches, enables, mode and manual clock button
`timescale 1ns/1ps
module switch_panel_model (
	// clock
	input  wire logic       core_clk_i,
	// switches
	output logic      [3:0] data_o,
	output logic            write_en_o,
	output logic            read_en_o,
	output logic            mode_o,
	output logic            manual_clk_o
);
	initial
	begin
		data_o = 4'h0;
		write_en_o = 1'b0;
		read_en_o = 1'b0;
		mode_o = 1'b0;
		manual_clk_o = 1'b0;
	end

	// settle switches, then one button rise, then release
	task automatic press(input logic wr, input logic rd, input logic [3:0] d);
		@(posedge core_clk_i);
		write_en_o <= wr;
		read_en_o <= rd;
		manual_clk_o <= 1'b0;
		if (wr)
			data_o <= d;
		@(posedge core_clk_i);
		manual_clk_o <= 1'b1;
		@(posedge core_clk_i);
		manual_clk_o <= 1'b0;
		write_en_o <= 1'b0;
		read_en_o <= 1'b0;
		// released data lines show no stale copy of the last value
		data_o <= ~data_o;
	endtask : press

	task automatic set_mode(input logic m);
		@(posedge core_clk_i);
		mode_o <= m;
	endtask : set_mode
endmodule : switch_panel_model

//--- testbench/dual_mode_queue_stack_memory_tb_top.sv
// self-checking bench for the queue/stack memory
`timescale 1ns/1ps
module dual_mode_queue_stack_memory_tb_top;
	import queue_stack_pkg::*;

	logic        core_clk_i = 1'b0;
	logic        resetn_i   = 1'b0;
	logic        hsel_i     = 1'b0;
	logic [31:0] haddr_i    = 32'h0000_0000;
	logic [1:0]  htrans_i   = 2'h0;
	logic        hwrite_i   = 1'b0;
	logic [2:0]  hsize_i    = 3'h2;
	logic [31:0] hwdata_i   = 32'h0000_0000;
	wire logic [31:0] hrdata_o;
	wire logic        hreadyout_o, hresp_o, dot_o, full_o, empty_o, valid_o;
	wire logic        disp_ovf_o, irq_o, write_en_i, read_en_i, mode_i, manual_clk_i;
	wire logic [6:0]  seg_o;
	wire logic [3:0]  data_in_i, data_out_o;
	int          mismatches = 0;
	int          n_checks   = 0;
	int          cycles     = 0;
	logic [3:0]  q[$];
	logic        stk = 1'b0;
	logic [31:0] rd;
	logic [6:0]  digit[10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
		7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};

	always #2 core_clk_i = ~core_clk_i;

	dual_mode_queue_stack_memory dut_u (.core_clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .data_in_i, .write_en_i, .read_en_i, .mode_i, .manual_clk_i, .seg_o,
		.dot_o, .data_out_o, .full_o, .empty_o, .valid_o, .disp_ovf_o, .irq_o);

	switch_panel_model panel_u (.core_clk_i, .data_o(data_in_i), .write_en_o(write_en_i),
		.read_en_o(read_en_i), .mode_o(mode_i), .manual_clk_o(manual_clk_i));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge core_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {24'h00_0000, a};
		hwrite_i <= wr;
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1)
			@(posedge core_clk_i);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		@(posedge core_clk_i);
		while (hreadyout_o !== 1'b1)
			@(posedge core_clk_i);
		rd = hrdata_o;
		// let the registers written at this edge settle before callers look
		#1;
	endtask : ahb

	task automatic check_state();
		ahb(1'b0, OFF_STATUS, 32'h0000_0000);
		check(rd[4:0], q.size());
		check(empty_o, q.size() == 0);
		check(full_o, q.size() == ENTRIES);
		check(disp_ovf_o, q.size() > 9);
		check(seg_o, q.size() > 9 ? 7'h00 : digit[q.size()]);
		check(dot_o, stk);
	endtask : check_state

	task automatic put(input logic [3:0] d);
		panel_u.press(1'b1, 1'b0, d);
		#1;
		if (q.size() < ENTRIES)
			q.push_back(d);
	endtask : put

	task automatic take();
		panel_u.press(1'b0, 1'b1, 4'h0);
		#1;
		if (q.size() == 0)
			check(valid_o, 0);
		else
		begin
			check(data_out_o, stk ? q.pop_back() : q.pop_front());
			check(valid_o, 1);
		end
	endtask : take

	task automatic mode(input logic m);
		panel_u.set_mode(m);
		stk = m;
	endtask : mode

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		check(valid_o, 0);
		check_state();
		ahb(1'b0, OFF_IRQ_MASK, 32'h0000_0000);
		check(rd, IRQ_MASK_RST);
		ahb(1'b0, 8'h10, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset

	task automatic t_order();
		put(4'h3);
		put(4'hA);
		put(4'h5);
		check(valid_o, 0);
		take();
		mode(1'b1);
		check_state();
		take();
		take();
		take();
		check_state();
		$display("order test done");
	endtask : t_order

	task automatic t_fill();
		mode(1'b0);
		for (int i = 0; i < ENTRIES + 1; i++)
		begin
			put(4'(i * 5));
			check_state();
		end
		for (int i = 0; i < ENTRIES; i++)
		begin
			if (i == 15)
				mode(1'b1);
			take();
		end
		check_state();
		$display("fill test done");
	endtask : t_fill

	task automatic t_irq();
		// every event kind has happened once by now
		ahb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_003F);
		ahb(1'b1, OFF_IRQ_STATUS, 32'h0000_003F);
		ahb(1'b1, OFF_IRQ_MASK, 32'h0000_0008);
		check(irq_o, 0);
		ahb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		take();
		repeat (2) @(posedge core_clk_i);
		#1;
		check(irq_o, 1);
		ahb(1'b0, OFF_IRQ_STATUS, 32'h0000_0000);
		check(rd[EV_RD_EMPTY], 1);
		ahb(1'b1, OFF_IRQ_STATUS, 32'h0000_0008);
		ahb(1'b1, OFF_IRQ_MASK, 32'h0000_0000);
		take();
		repeat (2) @(posedge core_clk_i);
		#1;
		check(irq_o, 0);
		ahb(1'b1, OFF_CTRL, 32'h0000_0091);
		repeat (2) @(posedge core_clk_i);
		q.push_back(4'h9);
		check_state();
		ahb(1'b1, OFF_CTRL, 32'h0000_0002);
		repeat (2) @(posedge core_clk_i);
		#1;
		check(data_out_o, q.pop_back());
		check_state();
		$display("interrupt test done");
	endtask : t_irq

	// reset in mid-run with a stored entry and a valid output
	task automatic t_rereset();
		put(4'h7);
		put(4'h2);
		take();
		@(posedge core_clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		q.delete();
		check(valid_o, 0);
		check(irq_o, 0);
		check_state();
		$display("second reset test done");
	endtask : t_rereset

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			close_out();
		end
	end

	initial
	begin
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		#1;
		t_reset();
		t_order();
		t_fill();
		t_irq();
		t_rereset();
		close_out();
	end
endmodule : dual_mode_queue_stack_memory_tb_top
